// *** psk_pkg.sv ***
// Shared constants and types for the dual keyboard/mouse serial port block
package psk_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLK_HZ = 100_000_000;
    localparam int LOOP_HZ = 2_000_000;
    localparam int LOOP_HALF_CYC = CLK_HZ / (2 * LOOP_HZ);
    localparam logic [4:0] LOOP_HALF_LAST = 5'(LOOP_HALF_CYC - 1);
    localparam int INHIBIT_US = 100;
    localparam int INHIBIT_CYC =
        (INHIBIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMEOUT_US = 2000;
    localparam int TIMEOUT_CYC = TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int TMR_W = 18;

    // Frame: start, 8 data, odd parity, stop
    localparam int FRAME_BITS = 11;
    localparam logic [3:0] RX_LAST = 4'(FRAME_BITS - 1);
    localparam logic [3:0] TX_LAST = 4'(FRAME_BITS - 1);

    // Register offsets within a port region, byte addresses
    localparam logic [3:0] OFS_ID = 4'h0;
    localparam logic [3:0] OFS_RESET = 4'h0;
    localparam logic [3:0] OFS_DATA = 4'h4;
    localparam logic [3:0] OFS_CTRL = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;
    localparam int PORT_SEL_BIT = 8;
    localparam logic [11:0] KBD_BASE = 12'h000;
    localparam logic [11:0] MOUSE_BASE = 12'h100;

    // Port identity codes and reset values
    localparam logic [3:0] ID_KEYBOARD = 4'h0;
    localparam logic [3:0] ID_MOUSE = 4'h1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'hE3;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // Buffer depths
    localparam logic [1:0] STAGE_FULL = 2'h2;
    localparam logic [2:0] RXQ_FULL = 3'h4;

    typedef struct packed {
        logic force_clock_line;
        logic force_data_line;
        logic line_override;
        logic [2:0] unused;
        logic internal_loopback;
        logic port_on;
    } psk_ctrl_type;

    typedef struct packed {
        logic clock_line_mirror;
        logic data_line_mirror;
        logic reserved;
        logic merged_irq;
        logic parity_fault;
        logic timeout_fault;
        logic tx_not_empty;
        logic rx_not_empty;
    } psk_status_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_INHIBIT = 2'b01,
        ST_SEND = 2'b11,
        ST_RECV = 2'b10
    } psk_state_type;

endpackage : psk_pkg

// *** psk_ps2_ports.sv ***
// Keyboard and mouse serial ports with host register access
`timescale 1ns/1ps

module psk_ps2_ports import psk_pkg::*; #(
    parameter int INHIBIT_CYCLES = INHIBIT_CYC,
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [11:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic host_irq_out,
    input wire logic [1:0] link_clk_in,
    input wire logic [1:0] link_data_in,
    output logic [1:0] link_clk_out,
    output logic [1:0] link_clk_oe_out,
    output logic [1:0] link_data_out,
    output logic [1:0] link_data_oe_out
);

    localparam logic [TMR_W-1:0] INH_LAST = TMR_W'(INHIBIT_CYCLES - 1);
    localparam logic [TMR_W-1:0] TMO_LAST = TMR_W'(TIMEOUT_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // Shared: loopback clock, decode, merged interrupt

    logic [4:0] loop_cnt;
    logic loop_clk;
    logic [1:0] port_irq;
    logic merged_q;
    logic [7:0] port_rd [2];

    wire [3:0] ofs = {reg_addr_in[3:2], 2'b00};
    wire port_sel = reg_addr_in[PORT_SEL_BIT];
    wire merged = |port_irq;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            loop_cnt <= 5'h00;
            loop_clk <= 1'b0;
        end else if (loop_cnt == LOOP_HALF_LAST) begin
            loop_cnt <= 5'h00;
            loop_clk <= ~loop_clk;
        end else begin
            loop_cnt <= loop_cnt + 5'h01;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            merged_q <= 1'b0;
            host_irq_out <= 1'b0;
            reg_rdata_out <= RDATA_RESET;
        end else begin
            merged_q <= merged;
            host_irq_out <= merged & ~merged_q;
            if (reg_rd_in) begin
                reg_rdata_out <= port_rd[port_sel];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-port logic

    for (genvar p = 0; p < 2; p++) begin : g_port
        localparam logic [3:0] PORT_ID = (p == 0) ? ID_KEYBOARD : ID_MOUSE;

        // [0] first stage, [1] synced
        logic [1:0] csync;
        logic [1:0] dsync;
        logic lclk_q;
        psk_ctrl_type ctrl;
        psk_state_type st;
        psk_state_type next_st;
        logic [3:0] rx_cnt;
        logic [3:0] tx_cnt;
        logic [9:0] rx_sh;
        logic [9:0] tx_sh;
        logic tx_bit;
        logic [7:0] tx_char;
        logic tx_full;
        logic [TMR_W-1:0] tmr;
        logic par_err;
        logic tmo_err;
        logic [7:0] stg [2];
        logic [1:0] stg_cnt;
        logic [7:0] rxq [4];
        logic [1:0] wp;
        logic [1:0] rp;
        logic [2:0] qcnt;
        psk_status_type status;

        wire sel = (port_sel == 1'(p));
        wire wr_rst = reg_wr_in & sel & (ofs == OFS_RESET);
        wire wr_tx = reg_wr_in & sel & (ofs == OFS_DATA);
        wire wr_ctl = reg_wr_in & sel & (ofs == OFS_CTRL);
        wire rd_rx = reg_rd_in & sel & (ofs == OFS_DATA);
        wire loop = ctrl.internal_loopback;
        wire lclk = loop ? loop_clk : csync[1];
        wire ldat = loop ? tx_bit : dsync[1];
        wire fall = lclk_q & ~lclk;
        wire rise = ~lclk_q & lclk;

        // Two-entry stage between the shifter and the receive buffer
        wire stg_in_rdy = (stg_cnt != STAGE_FULL);
        wire stg_out_vld = (stg_cnt != 2'h0);
        wire q_in_rdy = (qcnt != RXQ_FULL);
        wire move = stg_out_vld & q_in_rdy;
        wire pop = rd_rx & (qcnt != 3'h0);
        wire [1:0] stg_widx = move ? stg_cnt - 2'h1 : stg_cnt;

        // Busy also covers a full stage so no frame is dropped for lack of room
        wire busy = ~ctrl.port_on | par_err | ~stg_in_rdy;
        wire rx_take = loop ? (st == ST_SEND) & rise
                            : (st == ST_RECV) & fall;
        wire [9:0] rx_new = {ldat, rx_sh[9:1]};
        wire rx_done = rx_take & (rx_cnt == RX_LAST);
        wire par_bad = ~^rx_new[8:0];
        wire push = rx_done & ctrl.port_on;
        wire stg_push = push & stg_in_rdy;
        wire tmo_hit = ((st == ST_RECV) | (st == ST_SEND)) & (tmr == TMO_LAST);
        wire inh_end = (st == ST_INHIBIT) & (tmr == INH_LAST);
        wire start_rx = (st == ST_IDLE) & ~loop & fall & ~ldat & ~busy;
        wire start_tx = (st == ST_IDLE) & tx_full & ~start_rx
                        & (~loop | (fall & stg_in_rdy));
        wire tx_done = loop ? rx_done
                            : (st == ST_SEND) & fall & (tx_cnt == TX_LAST);

        always_comb begin
            next_st = st;
            unique case (st)
                ST_IDLE: begin
                    if (start_rx) begin
                        next_st = ST_RECV;
                    end else if (start_tx) begin
                        next_st = loop ? ST_SEND : ST_INHIBIT;
                    end
                end
                ST_INHIBIT: begin
                    if (inh_end) begin
                        next_st = ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (tx_done | tmo_hit) begin
                        next_st = ST_IDLE;
                    end
                end
                ST_RECV: begin
                    if (rx_done | tmo_hit) begin
                        next_st = ST_IDLE;
                    end
                end
            endcase
        end

        always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                csync <= 2'h3;
                dsync <= 2'h3;
                lclk_q <= 1'b1;
            end else begin
                csync <= {csync[0], link_clk_in[p]};
                dsync <= {dsync[0], link_data_in[p]};
                lclk_q <= lclk;
            end
        end

        always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                st <= ST_IDLE;
                tmr <= '0;
            end else begin
                st <= wr_rst ? ST_IDLE : next_st;
                if (wr_rst | (st != next_st) | fall) begin
                    tmr <= '0;
                end else if (st != ST_IDLE) begin
                    tmr <= tmr + 1'b1;
                end
            end
        end

        always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                ctrl <= psk_ctrl_type'(CTRL_RESET);
                par_err <= 1'b0;
                tmo_err <= 1'b0;
            end else if (wr_rst) begin
                ctrl <= psk_ctrl_type'(CTRL_RESET);
                par_err <= 1'b0;
                tmo_err <= 1'b0;
            end else begin
                if (wr_ctl) begin
                    ctrl <= psk_ctrl_type'(reg_wdata_in & CTRL_MASK);
                end
                par_err <= par_err | (push & par_bad);
                tmo_err <= tmo_err | tmo_hit;
            end
        end

        always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                rx_cnt <= 4'h0;
                rx_sh <= 10'h3FF;
            end else if (wr_rst) begin
                rx_cnt <= 4'h0;
            end else if (start_rx) begin
                rx_cnt <= 4'h1;
            end else if (start_tx) begin
                rx_cnt <= 4'h0;
            end else if (rx_take) begin
                rx_sh <= rx_new;
                rx_cnt <= rx_cnt + 4'h1;
            end
        end

        always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                tx_full <= 1'b0;
                tx_char <= 8'h00;
            end else if (wr_rst) begin
                tx_full <= 1'b0;
            end else if (wr_tx & ~tx_full) begin
                tx_char <= reg_wdata_in;
                tx_full <= 1'b1;
            end else if ((st == ST_SEND) & (tx_done | tmo_hit)) begin
                tx_full <= 1'b0;
            end
        end

        always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                tx_sh <= 10'h3FF;
                tx_bit <= 1'b1;
                tx_cnt <= 4'h0;
            end else if (wr_rst | (next_st == ST_IDLE)) begin
                tx_bit <= 1'b1;
            end else if (start_tx) begin
                tx_sh <= {1'b1, ~^tx_char, tx_char};
                tx_bit <= ~loop;
                tx_cnt <= 4'h0;
            end else if (inh_end) begin
                tx_bit <= 1'b0;
            end else if ((st == ST_SEND) & fall) begin
                tx_bit <= tx_sh[0];
                tx_sh <= {1'b1, tx_sh[9:1]};
                tx_cnt <= tx_cnt + 4'h1;
            end
        end

        always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                stg_cnt <= 2'h0;
                wp <= 2'h0;
                rp <= 2'h0;
                qcnt <= 3'h0;
            end else if (wr_rst) begin
                stg_cnt <= 2'h0;
                wp <= 2'h0;
                rp <= 2'h0;
                qcnt <= 3'h0;
            end else begin
                stg_cnt <= stg_cnt + {1'b0, stg_push} - {1'b0, move};
                wp <= wp + {1'b0, move};
                rp <= rp + {1'b0, pop};
                qcnt <= qcnt + {2'h0, move} - {2'h0, pop};
            end
        end

        always_ff @(posedge ref_clk_in) begin
            if (move) begin
                stg[0] <= stg[1];
                rxq[wp] <= stg[0];
            end
            if (stg_push) begin
                stg[stg_widx[0]] <= rx_new[7:0];
            end
        end

        // Open-drain lines: enable pulls the line low
        always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                link_clk_out[p] <= 1'b0;
                link_data_out[p] <= 1'b0;
                link_clk_oe_out[p] <= 1'b0;
                link_data_oe_out[p] <= 1'b0;
            end else begin
                link_clk_out[p] <= 1'b0;
                link_data_out[p] <= 1'b0;
                link_clk_oe_out[p] <= ctrl.line_override
                    ? ~ctrl.force_clock_line
                    : ~loop & ((st == ST_INHIBIT)
                      | ((st == ST_IDLE) & busy));
                link_data_oe_out[p] <= ctrl.line_override
                    ? ~ctrl.force_data_line
                    : ~loop & (st == ST_SEND) & ~tx_bit;
            end
        end

        assign port_irq[p] = ctrl.port_on & (qcnt != 3'h0);
        assign status = '{
            clock_line_mirror: csync[1],
            data_line_mirror: dsync[1],
            reserved: 1'b0,
            merged_irq: merged_q,
            parity_fault: par_err,
            timeout_fault: tmo_err,
            tx_not_empty: tx_full,
            rx_not_empty: (qcnt != 3'h0)
        };
        assign port_rd[p] = (ofs == OFS_ID) ? {4'h0, PORT_ID}
                          : (ofs == OFS_DATA) ? rxq[rp]
                          : (ofs == OFS_CTRL) ? ctrl
                          : status;
    end

endmodule : psk_ps2_ports

// *** psk_checker.sv ***
// Port-level assertions for the keyboard and mouse serial ports
`timescale 1ns/1ps
module psk_checker import psk_pkg::*; (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [11:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic host_irq_out,
    input wire logic [1:0] link_clk_in,
    input wire logic [1:0] link_data_in,
    input wire logic [1:0] link_clk_out,
    input wire logic [1:0] link_clk_oe_out,
    input wire logic [1:0] link_data_out,
    input wire logic [1:0] link_data_oe_out
);
default clocking @(posedge ref_clk_in); endclocking
default disable iff (!rst_b_in);
////////////////////////////////////////
// Shadow of each control register, and cycles since the lines last moved
logic [7:0] ctl [2];
logic [3:0] quiet;
logic [3:0] prev;
wire [1:0] sel = reg_addr_in[3:2];
wire port = reg_addr_in[8];
always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        ctl[0] <= 8'h00;
        ctl[1] <= 8'h00;
        prev <= 4'hF;
        quiet <= 4'h0;
    end else begin
        if (reg_wr_in && sel == 2'h2) ctl[port] <= reg_wdata_in & CTRL_MASK;
        else if (reg_wr_in && sel == 2'h0) ctl[port] <= 8'h00;
        prev <= {link_clk_in, link_data_in};
        if (prev != {link_clk_in, link_data_in}) quiet <= 4'h0;
        else if (quiet != 4'hF) quiet <= quiet + 4'h1;
    end
end
a_irq_pulse: assert property (
    host_irq_out |=> !host_irq_out) else $error("irq pulse too long");
a_id_code: assert property (
    reg_rd_in && sel == 2'h0 |=> reg_rdata_out == {7'h00, $past(port)})
    else $error("wrong identity code");
a_line_mirror: assert property (
    reg_rd_in && sel == 2'h3 && quiet > 4'h5 |=> reg_rdata_out[7:6] ==
    {$past(link_clk_in[port]), $past(link_data_in[port])})
    else $error("line mirror wrong");
a_ctrl_back: assert property (
    reg_rd_in && sel == 2'h2 |=> reg_rdata_out == $past(ctl[port]))
    else $error("control readback wrong");
a_off_busy0: assert property (
    (ctl[0] == 8'h00) [*4] |-> link_clk_oe_out[0])
    else $error("disabled port 0 not busy");
a_off_busy1: assert property (
    (ctl[1] == 8'h00) [*4] |-> link_clk_oe_out[1])
    else $error("disabled port 1 not busy");
a_line_override_lines: assert property (
    (ctl[0][5] && $stable(ctl[0])) [*3] |-> link_data_oe_out[0] ==
    !ctl[0][6] && link_clk_oe_out[0] == !ctl[0][7])
    else $error("override does not drive lines");
a_soft_reset: assert property (
    reg_wr_in && sel == 2'h0 && !port |-> ##[1:4]
    (link_clk_oe_out[0] && !link_data_oe_out[0]))
    else $error("soft reset did not idle port");
a_rdata_hold: assert property (
    !reg_rd_in |=> $stable(reg_rdata_out)) else $error("read data moved");
a_open_drain: assert property (
    link_clk_out == 2'h0 && link_data_out == 2'h0)
    else $error("line driven high");
endmodule : psk_checker
bind psk_ps2_ports psk_checker i_chk (.ref_clk_in, .rst_b_in,
    .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
    .host_irq_out, .link_clk_in, .link_data_in, .link_clk_out,
    .link_clk_oe_out, .link_data_out, .link_data_oe_out);

// *** psk_dev_model.sv ***
// Behavioural keyboard or mouse on one two-wire link
`timescale 1ns/1ps
module psk_dev_model (
    input wire logic line_clk_in,
    input wire logic line_data_in,
    output logic dev_clk_out,
    output logic dev_data_out,
    output logic [7:0] rx_byte_out,
    output logic rx_par_ok_out,
    output logic [7:0] rx_count_out
);
logic sending = 1'b0;
logic [8:0] sh;
initial begin
    dev_clk_out = 1'b1;
    dev_data_out = 1'b1;
    rx_byte_out = 8'h00;
    rx_par_ok_out = 1'b0;
    rx_count_out = 8'h00;
end
////////////////////////////////////////
// Clock stands high between frames; a busy port makes the frame wait
task automatic send(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    f = {1'b1, ~^b ^ bad, b, 1'b0};
    wait (line_clk_in === 1'b1);
    #3;
    sending = 1'b1;
    for (int i = 0; i < 11; i++) begin
        dev_data_out = f[i];
        #40 dev_clk_out = 1'b0;
        #80 dev_clk_out = 1'b1;
        #40;
    end
    dev_data_out = 1'b1;
    sending = 1'b0;
endtask : send
// Port request: data low with clock released
// Settle delays: our own release and a one-sided line change are no request
always begin
    #1;
    wait (!sending && line_data_in === 1'b0 && line_clk_in === 1'b1);
    #10;
    if (!sending && line_data_in === 1'b0 && line_clk_in === 1'b1) begin
        for (int k = 1; k < 12; k++) begin
            #40 dev_clk_out = 1'b0;
            if (k == 11) dev_data_out = 1'b0;
            #80 dev_clk_out = 1'b1;
            if (k < 10) sh[k - 1] = line_data_in;
            #40;
        end
        dev_data_out = 1'b1;
        rx_byte_out = sh[7:0];
        rx_par_ok_out = ^sh;
        rx_count_out = rx_count_out + 8'h01;
    end
end
endmodule : psk_dev_model

// *** tb.sv ***
// Self-checking bench for the keyboard and mouse serial ports
`timescale 1ns/1ps
module tb import psk_pkg::*;;
logic ref_clk_in = 1'b0;
logic rst_b_in = 1'b0;
logic [11:0] reg_addr_in = 12'h000;
logic reg_wr_in = 1'b0;
logic reg_rd_in = 1'b0;
logic [7:0] reg_wdata_in = 8'h00;
logic [7:0] reg_rdata_out;
logic host_irq_out;
wire [1:0] lclk, ldat, dclk, ddat;
logic [1:0] clk_o, clk_oe, dat_o, dat_oe, pok;
logic [1:0][7:0] rb, rc;
int errors = 0;
int checks = 0;
int irqs = 0;
integer seed = 32'h1724665A;
logic [7:0] v, w, q [$];
logic [7:0] dg [4] = '{8'h20, 8'h60, 8'hE1, 8'h01};
always #5 ref_clk_in = ~ref_clk_in;
// Pull-ups on both lines
assign lclk = ~clk_oe & dclk;
assign ldat = ~dat_oe & ddat;
always @(posedge ref_clk_in) if (host_irq_out === 1'b1) irqs++;
psk_ps2_ports #(.INHIBIT_CYCLES(20), .TIMEOUT_CYCLES(400)) i_dut (
    .ref_clk_in, .rst_b_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
    .reg_wdata_in, .reg_rdata_out, .host_irq_out,
    .link_clk_in(lclk), .link_data_in(ldat), .link_clk_out(clk_o),
    .link_clk_oe_out(clk_oe), .link_data_out(dat_o),
    .link_data_oe_out(dat_oe));
psk_dev_model i_kbd (.line_clk_in(lclk[0]), .line_data_in(ldat[0]),
    .dev_clk_out(dclk[0]), .dev_data_out(ddat[0]), .rx_byte_out(rb[0]),
    .rx_par_ok_out(pok[0]), .rx_count_out(rc[0]));
psk_dev_model i_mse (.line_clk_in(lclk[1]), .line_data_in(ldat[1]),
    .dev_clk_out(dclk[1]), .dev_data_out(ddat[1]), .rx_byte_out(rb[1]),
    .rx_par_ok_out(pok[1]), .rx_count_out(rc[1]));
////////////////////////////////////////
// Random upper address bits exercise the aliasing
function automatic logic [11:0] adr(input logic p, input logic [1:0] r);
    logic [11:0] a;
    a = 12'($random(seed));
    a[8] = p;
    a[3:2] = r;
    return a;
endfunction : adr
function automatic logic [7:0] st(input logic rx, tx, par, irq, dat, clk);
    return {clk, dat, 1'b0, irq, par, 1'b0, tx, rx};
endfunction : st
task automatic pause(input int n);
    repeat (n) @(posedge ref_clk_in);
endtask : pause
task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
endtask : wr
task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge ref_clk_in);
    #1 d = reg_rdata_out;
endtask : rd
task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
        errors++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask : chk
task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
endtask : rchk
task automatic close_out;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask : close_out
initial begin
    repeat (40000) @(posedge ref_clk_in);
    errors++;
    close_out;
end
////////////////////////////////////////
initial begin
    repeat (12) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    rchk(adr(0, 2'h0), {4'h0, ID_KEYBOARD});
    rchk(adr(1, 2'h0), {4'h0, ID_MOUSE});
    rchk(adr(0, 2'h2), 8'h00);
    rchk(adr(1, 2'h3), st(0, 0, 0, 0, 1, 0));
    wr(adr(0, 2'h2), 8'hFF);
    rchk(adr(0, 2'h2), CTRL_MASK);
    foreach (dg[i]) begin
        wr(adr(0, 2'h2), dg[i]);
        pause(6);
        rchk(adr(0, 2'h3), st(0, 0, 0, 0, !dg[i][5] | dg[i][6],
            dg[i][5] ? dg[i][7] : dg[i][0]));
    end
    wr(adr(1, 2'h2), 8'h01);
    for (int i = 0; i < 5; i++) begin
        v = (i == 0) ? 8'hFF : 8'($random(seed));
        q.push_back(v);
        if (i < 4) i_kbd.send(v, 1'b0);
        else i_mse.send(v, 1'b0);
    end
    pause(8);
    chk(8'(irqs), 8'h01);
    rchk(adr(1, 2'h3), st(1, 0, 0, 1, 1, 1));
    for (int i = 0; i < 5; i++) rchk(adr(i == 4, 2'h1), q.pop_front());
    rchk(adr(1, 2'h3), st(0, 0, 0, 0, 1, 1));
    v = 8'($random(seed));
    i_mse.send(v, 1'b0);
    pause(8);
    chk(8'(irqs), 8'h02);
    rchk(adr(1, 2'h1), v);
    v = 8'($random(seed));
    fork
        i_kbd.send(8'h00, 1'b0);
        begin
            pause(60);
            wr(adr(0, 2'h1), v);
            wr(adr(0, 2'h1), ~v);
            rd(adr(0, 2'h3), w);
            chk({6'h00, w[1:0]}, 8'h02);
        end
    join
    for (int i = 0; i < 3000 && rc[0] == 8'h00; i++) @(posedge ref_clk_in);
    chk(rb[0], v);
    chk({7'h00, pok[0]}, 8'h01);
    pause(4);
    rchk(adr(0, 2'h3), st(1, 0, 0, 1, 1, 1));
    chk(8'(irqs), 8'h03);
    rchk(adr(0, 2'h1), 8'h00);
    v = 8'($random(seed));
    w = 8'h00;
    wr(adr(1, 2'h2), 8'h03);
    wr(adr(1, 2'h1), v);
    for (int i = 0; i < 300 && w[0] !== 1'b1; i++) rd(adr(1, 2'h3), w);
    rchk(adr(1, 2'h1), v);
    chk(rc[1], 8'h00);
    v = 8'($random(seed));
    i_kbd.send(v, 1'b0);
    i_kbd.send(~v, 1'b1);
    pause(8);
    rchk(adr(0, 2'h3), st(1, 0, 1, 1, 1, 0));
    rchk(adr(0, 2'h1), v);
    rchk(adr(0, 2'h1), ~v);
    rchk(adr(0, 2'h3), st(0, 0, 1, 0, 1, 0));
    wr(adr(0, 2'h0), 8'hA5);
    pause(6);
    rchk(adr(0, 2'h3), st(0, 0, 0, 0, 1, 0));
    rchk(adr(0, 2'h2), 8'h00);
    close_out;
end
endmodule : tb
